// ===== bench/brtc_host.sv
`timescale 1ns/1ps
`default_nettype none
module brtc_host (
   // clock
   input  wire logic               clock,
   // host strobes and data
   output var brtc_pkg::brtc_bus_s hbus,
   output logic                    abort_n,
   // device drive of the data line
   input  wire logic               rd_data,
   input  wire logic               rd_oe_n
);
   initial begin
      hbus = '{1'b1, 1'b1, 1'b1, 1'b0};
      abort_n = 1'b1;
   end
   // released line flips so a stale bit never passes for a driven one
   task automatic wr(input logic b);
      @(posedge clock);
      hbus <= '{1'b0, 1'b1, 1'b0, b};
      @(posedge clock);
      hbus <= '{1'b1, 1'b1, 1'b1, ~b};
      @(posedge clock);
   endtask
   task automatic rd(output logic b);
      int n;
      @(posedge clock);
      hbus <= '{1'b0, 1'b0, 1'b1, hbus.serial_data_line};
      n = 0;
      do begin
         @(posedge clock);
         #1 n++;
      end while (rd_oe_n !== 1'b0 && n < 4);
      // an undriven line yields unknown, never a stale bit
      b = (rd_oe_n === 1'b0) ? rd_data : 1'bx;
      @(posedge clock);
      hbus <= '{1'b1, 1'b1, 1'b1, hbus.serial_data_line};
      @(posedge clock);
   endtask
   task automatic unlock();
      logic d;
      rd(d);
      for (int i = 0; i < 64; i++) wr(brtc_pkg::UNLOCK_PATTERN[i]);
   endtask
   task automatic rdn(input int n, output logic [63:0] v);
      logic d;
      v = '0;
      for (int i = 0; i < n; i++) begin
         rd(d);
         v[i] = d;
      end
   endtask
   task automatic xfer_wr(input logic [63:0] v);
      unlock();
      for (int i = 0; i < 64; i++) wr(v[i]);
   endtask
   // abort raised together with a write strobe
   task automatic abort_mid();
      @(posedge clock);
      hbus <= '{1'b0, 1'b1, 1'b0, 1'b1};
      abort_n <= 1'b0;
      repeat (2) @(posedge clock);
      hbus <= '{1'b1, 1'b1, 1'b1, 1'b0};
      abort_n <= 1'b1;
      @(posedge clock);
   endtask
endmodule
`default_nettype wire

// ===== bench/brtc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module brtc_top_tb;
   logic                clock;
   logic                rst_n;
   brtc_pkg::brtc_bus_s hbus;
   brtc_pkg::brtc_bus_s dbus;
   logic                abort_n;
   logic                dq_out;
   logic                dq_oe_n;
   logic                mem_disable;
   logic [63:0]         got;
   int                  err_total = 0;
   int                  samples_checked = 0;
   int                  cyc_cnt = 0;
   // shared data line: device wins while its enable is low
   always_comb begin
      dbus = hbus;
      dbus.serial_data_line = dq_oe_n ? hbus.serial_data_line : dq_out;
   end
   brtc_top #(.TICK_CYC(100), .PATTERN(brtc_pkg::UNLOCK_PATTERN)) i_brtc_top (
      .clock(clock), .rst_n(rst_n), .bus(dbus), .abort_n(abort_n),
      .serial_data_line_out(dq_out), .serial_data_line_oe_n(dq_oe_n),
      .mem_disable(mem_disable));
   brtc_host i_brtc_host (.clock(clock), .hbus(hbus), .abort_n(abort_n),
      .rd_data(dq_out), .rd_oe_n(dq_oe_n));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   task automatic wrap_up();
      $display("errors=%0d checks=%0d", err_total, samples_checked);
      if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // about ten transfers need well under this
   always @(posedge clock) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 30000) begin
         err_total++;
         wrap_up();
      end
   end
   task automatic chk64(input logic [63:0] g, input logic [63:0] e);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic read_all(output logic [63:0] v);
      i_brtc_host.unlock();
      i_brtc_host.rdn(64, v);
   endtask
   // halted, ones in every fixed-zero place
   task automatic sc_fields();
      i_brtc_host.xfer_wr(64'h99F2D5EBF1C5D942);
      read_all(got);
      chk64(got, 64'h99121523B1455942);
   endtask
   task automatic sc_pattern();
      logic d;
      i_brtc_host.rd(d);
      i_brtc_host.wr(~brtc_pkg::UNLOCK_PATTERN[0]);
      for (int i = 1; i < 64; i++) i_brtc_host.wr(brtc_pkg::UNLOCK_PATTERN[i]);
      chk1(mem_disable, 1'b0);
      for (int i = 0; i < 10; i++) i_brtc_host.wr(brtc_pkg::UNLOCK_PATTERN[i]);
      i_brtc_host.unlock();
      repeat (2) @(posedge clock);
      #1 chk1(mem_disable, 1'b1);
      i_brtc_host.rdn(64, got);
      chk64(got, 64'h99121523B1455942);
   endtask
   task automatic sc_abort();
      i_brtc_host.unlock();
      i_brtc_host.abort_mid();
      #1 chk1(mem_disable, 1'b0);
      read_all(got);
      chk64(got, 64'h99121523B1455942);
   endtask
   // abort ignored: the strobed bit lands in reg 0 bit 0
   task automatic sc_ignore();
      i_brtc_host.xfer_wr(64'h99121533B1455942);
      i_brtc_host.unlock();
      i_brtc_host.abort_mid();
      #1 chk1(mem_disable, 1'b1);
      i_brtc_host.rdn(63, got);
      read_all(got);
      chk64(got, 64'h99121533B1455943);
   endtask
   // sub-second drifts with transfer length, so only a small range is checked
   task automatic sc_run();
      i_brtc_host.xfer_wr(64'h0703050223595999);
      read_all(got);
      chk64({8'h00, got[63:8]}, 64'h0007030603000000);
      chk1((got[7:0] >= 8'h01) && (got[7:0] <= 8'h05), 1'b1);
   endtask
   // 12-hour mode: 11 AM rolls into noon with the PM flag set
   task automatic sc_noon();
      i_brtc_host.xfer_wr(64'h0701050291595999);
      read_all(got);
      chk64({8'h00, got[63:8]}, 64'h0007010502B20000);
      chk1((got[7:0] >= 8'h01) && (got[7:0] <= 8'h05), 1'b1);
   endtask
   initial begin
      rst_n = 1'b0;
      repeat (12) @(posedge clock);
      chk1(dq_oe_n, 1'b1);
      chk1(mem_disable, 1'b0);
      rst_n <= 1'b1;
      @(posedge clock);
      sc_fields();
      sc_pattern();
      sc_abort();
      sc_ignore();
      sc_run();
      sc_noon();
      wrap_up();
   end
endmodule
`default_nettype wire

// ===== hdl/brtc_pkg.sv
package brtc_pkg;
   localparam int NUM_REGS = 8;
   localparam int XFER_BITS = 64;
   localparam int PAT_BITS = 64;
   localparam logic [5:0] LAST_BIT = 6'h3F;
   localparam int REG_SUBSEC = 0;
   localparam int REG_SEC = 1;
   localparam int REG_MIN = 2;
   localparam int REG_HOUR = 3;
   localparam int REG_WDAY = 4;
   localparam int REG_DATE = 5;
   localparam int REG_MONTH = 6;
   localparam int REG_YEAR = 7;
   localparam int HR_FMT_BIT = 7;
   localparam int HR_PM_BIT = 5;
   localparam int ABORT_IGN_BIT = 4;
   localparam int HALT_BIT = 5;
   localparam int MONTH_TENS_BIT = 4;
   // reg 7 in the top byte, reg 0 in the low byte
   localparam logic [63:0] REG_MASKS = 64'hFF1F3F37BF7F7FFF;
   localparam logic [63:0] RESET_VALS = 64'h0001010100000000;
   // arbitrary default unlock sequence
   localparam logic [63:0] UNLOCK_PATTERN = 64'hC53AA35CC53AA35C;
   localparam int CLK_PERIOD_NS = 8;
   localparam int TICK_PERIOD_NS = 10000000;
   localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

   typedef enum logic {PH_MATCH, PH_XFER} brtc_state_e;

   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic serial_data_line;
   } brtc_bus_s;
endpackage

// ===== hdl/brtc_top.sv
`timescale 1ns/1ps
`default_nettype none
module brtc_top #(
   parameter int          TICK_CYC = brtc_pkg::TICK_CYCLES,
   parameter logic [63:0] PATTERN  = brtc_pkg::UNLOCK_PATTERN
) (
   // clock and reset
   input  wire logic                clock,
   input  wire logic                rst_n,
   // memory-style host port
   input  wire brtc_pkg::brtc_bus_s bus,
   input  wire logic                abort_n,
   // serial data line drive and memory disable
   output logic                     serial_data_line_out,
   output logic                     serial_data_line_oe_n,
   output logic                     mem_disable
);
   brtc_pkg::brtc_state_e phase_r;
   logic [7:0][7:0] cnt_r, cnt_nxt;
   logic [63:0]     shadow_r;
   logic [5:0]      ptr_r, idx_r;
   logic            miss_r, wrote_r, load_r, tick_r;
   logic            rd_prev_r, wr_prev_r, dq_prev_r;
   logic [31:0]     div_r;
   logic            rd_act, wr_act, rd_start, wr_end, abort_hit, halted;

   function automatic logic [8:0] bcd_inc(logic [7:0] v, logic [7:0] lo, logic [7:0] hi);
      if (v >= hi)
         return {1'b1, lo};
      if (v[3:0] >= 4'h9)
         return {1'b0, v[7:4] + 4'h1, 4'h0};
      return {1'b0, v[7:4], v[3:0] + 4'h1};
   endfunction

   function automatic logic [7:0] month_len(logic [7:0] m, logic [7:0] y);
      logic leap;
      leap = (!y[4] && (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8)) ||
             (y[4] && (y[3:0] == 4'h2 || y[3:0] == 4'h6));
      if (m == 8'h02)
         return leap ? 8'h29 : 8'h28;
      if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11)
         return 8'h30;
      return 8'h31;
   endfunction

   assign rd_act    = !bus.ce_n && !bus.oe_n && bus.we_n;
   assign wr_act    = !bus.ce_n && !bus.we_n;
   assign rd_start  = rd_act && !rd_prev_r;
   // write data is taken at the closing edge, where setup is specified
   assign wr_end    = !wr_act && wr_prev_r;
   assign abort_hit = !abort_n && !cnt_r[brtc_pkg::REG_WDAY][brtc_pkg::ABORT_IGN_BIT];
   assign halted    = cnt_r[brtc_pkg::REG_WDAY][brtc_pkg::HALT_BIT];

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_prev_r <= 1'b0;
         wr_prev_r <= 1'b0;
         dq_prev_r <= 1'b0;
      end else begin
         rd_prev_r <= rd_act;
         wr_prev_r <= wr_act;
         dq_prev_r <= bus.serial_data_line;
      end
   end

   // timebase divider, 100 Hz
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         div_r  <= 32'h00000000;
         tick_r <= 1'b0;
      end else if (div_r == 32'(TICK_CYC - 1)) begin
         div_r  <= 32'h00000000;
         tick_r <= 1'b1;
      end else begin
         div_r  <= div_r + 32'h00000001;
         tick_r <= 1'b0;
      end
   end

   // carry chain; BCD throughout
   always_comb begin
      logic [8:0] r;
      logic [7:0] h;
      logic       cy;
      r       = 9'h000;
      h       = 8'h00;
      cy      = 1'b0;
      cnt_nxt = cnt_r;
      r = bcd_inc(cnt_r[0], 8'h00, 8'h99);
      cnt_nxt[0] = r[7:0];
      cy = r[8];
      if (cy) begin
         r = bcd_inc(cnt_r[1], 8'h00, 8'h59);
         cnt_nxt[1] = r[7:0];
         cy = r[8];
      end
      if (cy) begin
         r = bcd_inc(cnt_r[2], 8'h00, 8'h59);
         cnt_nxt[2] = r[7:0];
         cy = r[8];
      end
      if (cy) begin
         if (cnt_r[3][brtc_pkg::HR_FMT_BIT]) begin
            h  = {3'b000, cnt_r[3][4:0]};
            cy = 1'b0;
            if (h == 8'h12) begin
               cnt_nxt[3] = {cnt_r[3][7:5], 5'h01};
            end else if (h == 8'h11) begin
               // 11 PM rolls to 12 AM and starts a new day
               cy = cnt_r[3][brtc_pkg::HR_PM_BIT];
               cnt_nxt[3] = {cnt_r[3][7:6], !cnt_r[3][brtc_pkg::HR_PM_BIT], 5'h12};
            end else begin
               r = bcd_inc(h, 8'h01, 8'h12);
               cnt_nxt[3] = {cnt_r[3][7:5], r[4:0]};
            end
         end else begin
            r = bcd_inc({2'b00, cnt_r[3][5:0]}, 8'h00, 8'h23);
            cnt_nxt[3] = {cnt_r[3][7:6], r[5:0]};
            cy = r[8];
         end
      end
      if (cy) begin
         r = bcd_inc({5'h00, cnt_r[4][2:0]}, 8'h01, 8'h07);
         cnt_nxt[4] = {cnt_r[4][7:3], r[2:0]};
         r = bcd_inc(cnt_r[5], 8'h01, month_len(cnt_r[6], cnt_r[7]));
         cnt_nxt[5] = r[7:0];
         cy = r[8];
      end
      if (cy) begin
         r = bcd_inc(cnt_r[6], 8'h01, 8'h12);
         cnt_nxt[6] = r[7:0];
         cy = r[8];
      end
      if (cy) begin
         r = bcd_inc(cnt_r[7], 8'h00, 8'h99);
         cnt_nxt[7] = r[7:0];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         cnt_r <= brtc_pkg::RESET_VALS;
      else if (load_r)
         cnt_r <= shadow_r & brtc_pkg::REG_MASKS;
      else if (tick_r && !halted)
         cnt_r <= cnt_nxt;
   end

   // unlock and serial transfer
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         phase_r  <= brtc_pkg::PH_MATCH;
         ptr_r    <= 6'h00;
         idx_r    <= 6'h00;
         miss_r   <= 1'b0;
         wrote_r  <= 1'b0;
         load_r   <= 1'b0;
         shadow_r <= 64'h0000000000000000;
      end else begin
         load_r <= 1'b0;
         if (abort_hit) begin
            // dropped without touching the counters
            phase_r <= brtc_pkg::PH_MATCH;
            ptr_r   <= 6'h00;
            miss_r  <= 1'b0;
            wrote_r <= 1'b0;
         end else if (phase_r == brtc_pkg::PH_MATCH) begin
            if (rd_start) begin
               ptr_r  <= 6'h00;
               miss_r <= 1'b0;
            end else if (wr_end && !miss_r) begin
               if (dq_prev_r != PATTERN[ptr_r]) begin
                  miss_r <= 1'b1;
               end else if (ptr_r == brtc_pkg::LAST_BIT) begin
                  phase_r  <= brtc_pkg::PH_XFER;
                  ptr_r    <= 6'h00;
                  idx_r    <= 6'h00;
                  wrote_r  <= 1'b0;
                  shadow_r <= cnt_r;
               end else begin
                  ptr_r <= ptr_r + 6'h01;
               end
            end
         end else if (rd_start || wr_end) begin
            if (wr_end)
               shadow_r[idx_r] <= dq_prev_r;
            idx_r <= idx_r + 6'h01;
            if (idx_r == brtc_pkg::LAST_BIT) begin
               phase_r <= brtc_pkg::PH_MATCH;
               load_r  <= wrote_r || wr_end;
            end
            wrote_r <= wrote_r || wr_end;
         end
      end
   end

   // output pins
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         serial_data_line_out  <= 1'b0;
         serial_data_line_oe_n <= 1'b1;
         mem_disable           <= 1'b0;
      end else begin
         mem_disable <= (phase_r == brtc_pkg::PH_XFER) && !abort_hit;
         if (abort_hit || !rd_act) begin
            serial_data_line_oe_n <= 1'b1;
         end else if (rd_start && phase_r == brtc_pkg::PH_XFER) begin
            serial_data_line_out  <= shadow_r[idx_r];
            serial_data_line_oe_n <= 1'b0;
         end
      end
   end

   abort_cancel_a: assert property (@(posedge clock) disable iff (!rst_n)
      (phase_r == brtc_pkg::PH_XFER && abort_hit) |=> phase_r == brtc_pkg::PH_MATCH && !load_r)
      else $error("abort did not cancel transfer");
   abort_ignore_a: assert property (@(posedge clock) disable iff (!rst_n)
      (phase_r == brtc_pkg::PH_XFER && !abort_n && cnt_r[4][4] && !rd_start && !wr_end)
      |=> phase_r == brtc_pkg::PH_XFER)
      else $error("abort honoured while ignored");
   zero_bits_a: assert property (@(posedge clock) disable iff (!rst_n)
      ##1 (cnt_r & ~brtc_pkg::REG_MASKS) == 64'h0000000000000000)
      else $error("fixed-zero bit set");
   halt_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
      (halted && !load_r) |=> $stable(cnt_r[0]))
      else $error("counter moved while halted");
   subsec_wrap_a: assert property (@(posedge clock) disable iff (!rst_n)
      (tick_r && !halted && !load_r && cnt_r[0] == 8'h99) |=> cnt_r[0] == 8'h00 &&
      cnt_r[1] != $past(cnt_r[1]))
      else $error("hundredths wrap or carry wrong");
   read_reset_a: assert property (@(posedge clock) disable iff (!rst_n)
      (phase_r == brtc_pkg::PH_MATCH && rd_start && !abort_hit) |=> ptr_r == 6'h00 && !miss_r)
      else $error("read did not reset pointer");
   unlock_full_a: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(phase_r == brtc_pkg::PH_XFER) |-> $past(ptr_r) == brtc_pkg::LAST_BIT)
      else $error("unlocked before 64 matches");
   day_roll_a: assert property (@(posedge clock) disable iff (!rst_n)
      (tick_r && !halted && !load_r && cnt_r[3:0] == 32'h23595999) |=> cnt_r[3] == 8'h00)
      else $error("24-hour rollover wrong");
   noon_flip_a: assert property (@(posedge clock) disable iff (!rst_n)
      (tick_r && !halted && !load_r && cnt_r[3:0] == 32'h91595999) |=> cnt_r[3] == 8'hB2)
      else $error("12-hour noon flip wrong");
   snapshot_a: assert property (@(posedge clock) disable iff (!rst_n)
      (phase_r == brtc_pkg::PH_XFER && !wr_end) |=> $stable(shadow_r))
      else $error("snapshot changed during transfer");
endmodule
`default_nettype wire
